// *** hdl/spe_map.svh ***
// Constants for the serial programming entry block
`ifndef SPE_MAP_SVH
`define SPE_MAP_SVH
`define SPE_KEY_BITS 32
`define SPE_KEY_VALUE 32'h5a5a_c3c3
`define SPE_CNT_W 6
`define SPE_SYNC_RST 1'b0
`endif

// *** hdl/spe_pkg.sv ***
// Types shared by the serial programming entry block
`default_nettype none
package spe_pkg;
    typedef enum logic [2:0] {
        SPE_IDLE,
        SPE_KEY_SHIFT,
        SPE_KEY_FAIL,
        SPE_HV_SESSION,
        SPE_LV_SESSION
    } spe_mode_e;
endpackage
`default_nettype wire

// *** hdl/spe_sync2.sv ***
// Two-flop synchroniser for pin inputs
`default_nettype none
module spe_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // First stage, read only by the second
    logic [WIDTH-1:0] meta_q;

    // Two stages, cleared by reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** hdl/spe_entry.sv ***
// Serial programming entry and mode-hold logic
`include "spe_map.svh"
`default_nettype none
// Functional notes
// - HV entry: clock, data low, then high level
// - Key entry only when enable bit is 1
// - Master-clear low, then 32-bit key shifted
// - Key session lasts while master-clear stays low
// - Enable bit forces master-clear reset on
// - Clearing enable bit allowed in HV session only
// - Data pin two-way, clock pin input only
// - Session allows memory, ID, config writes
module spe_entry #(
    parameter int KEY_BITS = `SPE_KEY_BITS,
    parameter logic [`SPE_KEY_BITS-1:0] ENTRY_KEY = `SPE_KEY_VALUE
) (
    input wire logic clk_sys,
    input wire logic srst,
    // Programmer pins, inputs outside the clock's domain, outputs registered in it
    input wire logic prog_serial_clock,
    input wire logic prog_serial_data_in,
    output logic prog_serial_data_out,
    output logic prog_serial_data_oe,
    input wire logic master_clear_pin,
    input wire logic high_programming_level,
    // Config bit and outgoing data, same clock domain
    input wire logic low_voltage_entry_enable,
    input wire logic tx_data,
    input wire logic tx_drive,
    // Enable-bit clear request and its grant
    input wire logic cfg_lv_clear_req,
    output logic cfg_lv_clear_ok,
    // Mode status and permissions, all registered
    output logic master_clear_reset_forced,
    output logic prog_mode_active,
    output logic hv_session,
    output logic lv_session,
    output logic prog_write_enable,
    output logic rx_bit_valid,
    output logic rx_bit
);
    import spe_pkg::*;

    // Synchronised pins: clock, data, master-clear, high level
    logic [3:0] pins_s;
    // Named taps of the synchroniser output
    logic clk_s; // Serial clock, two flops late
    logic dat_s; // Serial data, same delay as the clock
    logic mclr_s; // Master-clear level, high when released
    logic hv_s; // High programming level present
    // Edge finder state for the serial clock
    logic clk_prev_q; // Serial clock one cycle back
    logic clk_rise; // One-cycle strobe per clock rise
    // Key receiver state
    logic [`SPE_CNT_W-1:0] bit_cnt_q; // Bits taken so far
    logic [`SPE_KEY_BITS-1:0] shift_q; // Received key, MSB first
    // Entry mode machine
    spe_mode_e mode_q; // Present mode
    // Edge finder state for the high level
    logic hv_prev_q; // High level one cycle back
    logic hv_armed; // High level just arrived with pins low

    // All four pins share one two-flop stage, so clock and data
    // keep their relative timing through the crossing
    // Bit 0 clock, 1 data, 2 master-clear, 3 high level
    spe_sync2 #(
        .WIDTH(4)
    ) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .async_in({high_programming_level, master_clear_pin,
                   prog_serial_data_in, prog_serial_clock}),
        .sync_out(pins_s)
    );

    // Bit order fixed by the concatenation above
    assign clk_s = pins_s[0];
    assign dat_s = pins_s[1];
    assign mclr_s = pins_s[2];
    assign hv_s = pins_s[3];

    // Edge finder on the synchronised serial clock
    // Reset value matches the idle low level of both pins,
    // so no false edge follows reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clk_prev_q <= `SPE_SYNC_RST;
            hv_prev_q <= `SPE_SYNC_RST;
        end else begin
            clk_prev_q <= clk_s;
            hv_prev_q <= hv_s;
        end
    end

    // A rise shows two cycles after the pin edge; the link
    // clock must stay well below the system clock for this to work
    assign clk_rise = clk_s & ~clk_prev_q;
    // Clock and data must both be low as the high level arrives
    assign hv_armed = hv_s & ~hv_prev_q & ~clk_s & ~dat_s;

    // Key receiver: cleared while master-clear is high
    // Also cleared in idle, so a key cut short by the enable bit
    // leaves no stale count for the next attempt
    always_ff @(posedge clk_sys) begin
        if (srst || mclr_s) begin
            bit_cnt_q <= '0;
            shift_q <= '0;
        end else if (mode_q == SPE_IDLE) begin
            // Fresh start for the next key
            bit_cnt_q <= '0;
            shift_q <= '0;
        end else if (mode_q == SPE_KEY_SHIFT && clk_rise &&
                     bit_cnt_q != `SPE_CNT_W'(KEY_BITS)) begin
            // New bit enters at the bottom; the first bit ends as MSB
            shift_q <= {shift_q[`SPE_KEY_BITS-2:0], dat_s};
            bit_cnt_q <= bit_cnt_q + `SPE_CNT_W'(1);
        end
    end

    // Mode machine
    // A session is left only through the pin that opened it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_q <= SPE_IDLE;
        end else begin
            unique case (mode_q)
                SPE_IDLE: begin
                    // High-voltage entry wins over the key path
                    if (hv_armed) begin
                        mode_q <= SPE_HV_SESSION;
                    end else if (!mclr_s && low_voltage_entry_enable) begin
                        mode_q <= SPE_KEY_SHIFT;
                    end
                end
                SPE_KEY_SHIFT: begin
                    // Shifting itself happens in the key receiver
                    // Enable may drop; the path then closes
                    if (mclr_s || !low_voltage_entry_enable) begin
                        mode_q <= SPE_IDLE;
                    end else if (bit_cnt_q == `SPE_CNT_W'(KEY_BITS)) begin
                        // Whole key in: compare once
                        if (shift_q == ENTRY_KEY) begin
                            mode_q <= SPE_LV_SESSION;
                        end else begin
                            mode_q <= SPE_KEY_FAIL;
                        end
                    end
                end
                SPE_KEY_FAIL: begin
                    // Locked out until master-clear rises again
                    if (mclr_s) begin
                        mode_q <= SPE_IDLE;
                    end
                end
                SPE_HV_SESSION: begin
                    // Session held while the high level stays
                    // Master-clear level plays no part here
                    if (!hv_s) begin
                        mode_q <= SPE_IDLE;
                    end
                end
                SPE_LV_SESSION: begin
                    // Release of master-clear ends the session
                    // Enable bit changes do not end a running session
                    if (mclr_s) begin
                        mode_q <= SPE_IDLE;
                    end
                end
                default: begin
                    // Unused codes fall back to idle
                    mode_q <= SPE_IDLE;
                end
            endcase
        end
    end

    // Session flags and permissions, registered
    // Registering costs a cycle of latency but keeps the
    // outputs glitch-free for the memory write logic
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            // Nothing granted out of reset
            hv_session <= 1'b0;
            lv_session <= 1'b0;
            prog_mode_active <= 1'b0;
            prog_write_enable <= 1'b0;
            cfg_lv_clear_ok <= 1'b0;
            master_clear_reset_forced <= 1'b0;
        end else begin
            hv_session <= (mode_q == SPE_HV_SESSION);
            lv_session <= (mode_q == SPE_LV_SESSION);
            prog_mode_active <= (mode_q == SPE_HV_SESSION) || (mode_q == SPE_LV_SESSION);
            // Writes allowed in either kind of session
            prog_write_enable <= (mode_q == SPE_HV_SESSION) ||
                (mode_q == SPE_LV_SESSION);
            // Enable bit clear only from an HV session; by programmer
            cfg_lv_clear_ok <= cfg_lv_clear_req && (mode_q == SPE_HV_SESSION);
            // No other setting can mask this
            master_clear_reset_forced <= low_voltage_entry_enable;
        end
    end

    // Serial data path both ways while in session
    // The drive enable is gated by the session, so a stray drive
    // request outside a session never fights the programmer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            // Pin released out of reset
            prog_serial_data_out <= 1'b0;
            prog_serial_data_oe <= 1'b0;
            rx_bit_valid <= 1'b0;
            rx_bit <= 1'b0;
        end else begin
            // Outgoing bit follows the core one cycle later
            prog_serial_data_out <= tx_data;
            prog_serial_data_oe <= tx_drive && prog_mode_active;
            // Strobe only while the device is not driving the pin
            rx_bit_valid <= clk_rise && prog_mode_active && !tx_drive;
            rx_bit <= dat_s;
        end
    end
endmodule
`default_nettype wire

// *** verification/spe_entry_assertions.sv ***
// Port-level checks for the serial programming entry block
`default_nettype none
module spe_entry_chk (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic master_clear_pin,
    input wire logic high_programming_level,
    input wire logic low_voltage_entry_enable,
    input wire logic cfg_lv_clear_ok,
    input wire logic master_clear_reset_forced,
    input wire logic prog_mode_active,
    input wire logic hv_session,
    input wire logic lv_session,
    input wire logic prog_write_enable,
    input wire logic rx_bit_valid,
    input wire logic prog_serial_data_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // One domain, so clock and reset are given once
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    chk_force_copy: assert property (
        1 |=> master_clear_reset_forced == $past(low_voltage_entry_enable))
        else $error("reset force wrong");
    chk_lv_enable: assert property ($rose(lv_session) |-> low_voltage_entry_enable)
        else $error("key entry while disabled");
    chk_lv_hold: assert property (lv_session && master_clear_pin |-> ##[1:8] !lv_session)
        else $error("key session outlived release");
    chk_mclr_idle: assert property (master_clear_pin [*8] |-> !lv_session)
        else $error("key session with pin high");
    chk_clear_hv: assert property (cfg_lv_clear_ok |-> !lv_session)
        else $error("clear granted in key session");
    chk_write_mode: assert property (prog_write_enable |-> prog_mode_active)
        else $error("write outside session");
    chk_hv_drop: assert property (
        hv_session && !high_programming_level |-> ##[1:8] !hv_session)
        else $error("high session outlived level");
    chk_rx_pulse: assert property (rx_bit_valid |=> !rx_bit_valid)
        else $error("bit strobe too long");
    chk_oe_session: assert property (prog_serial_data_oe |-> $past(prog_mode_active))
        else $error("data driven outside session");
    // Main scenarios reached
    cover property (lv_session);
    cover property (hv_session);
    cover property (cfg_lv_clear_ok);
    cover property (prog_serial_data_oe);
endmodule
bind spe_entry spe_entry_chk spe_entry_chk_i (.clk_sys, .srst, .master_clear_pin,
    .high_programming_level, .low_voltage_entry_enable, .cfg_lv_clear_ok,
    .master_clear_reset_forced, .prog_mode_active, .hv_session, .lv_session,
    .prog_write_enable, .rx_bit_valid, .prog_serial_data_oe);
`default_nettype wire

// *** verification/spe_prog_model.sv ***
// Programmer model driving the serial programming pins
`default_nettype none
module spe_prog_model (
    input wire logic clk_sys,
    output logic pclk,
    output logic pdat,
    output logic mclr,
    output logic hvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle pins; link clock parked low between frames
    initial begin
        pclk = 1'b0;
        pdat = 1'b0;
        mclr = 1'b1;
        hvl = 1'b0;
    end
    // Pin levels between frames: master-clear, high level, data
    task automatic drive_pins(input logic m, input logic h, input logic d);
        mclr <= m;
        hvl <= h;
        pdat <= d;
    endtask
    // Key shift MSB first, 800 ns per bit, data set while clock low
    task automatic key(input logic [31:0] k);
        for (int i = 31; i >= 0; i--) begin
            pdat <= k[i];
            repeat (4) @(posedge clk_sys);
            pclk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            pclk <= 1'b0;
        end
        pdat <= ~k[0]; // Released line shows the inverse
    endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the serial programming entry block
`include "spe_map.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, srst = 1'b1, en = 1'b1, txd = 1'b0, txe = 1'b0, req = 1'b0;
    logic pclk, pdat, mclr, hvl, dout, doe, ok, frc, mode, hv, lv, wen, rxv, rxb;
    int errors = 0, n_checks = 0, nrx = 0;
    logic [31:0] rxw = 32'h0;
    wire logic dline = doe ? dout : pdat;
    spe_entry spe_entry_i (.clk_sys, .srst, .prog_serial_clock(pclk), .prog_serial_data_in(dline),
        .prog_serial_data_out(dout), .prog_serial_data_oe(doe), .master_clear_pin(mclr),
        .high_programming_level(hvl), .low_voltage_entry_enable(en), .tx_data(txd),
        .tx_drive(txe), .cfg_lv_clear_req(req), .cfg_lv_clear_ok(ok),
        .master_clear_reset_forced(frc), .prog_mode_active(mode), .hv_session(hv),
        .lv_session(lv), .prog_write_enable(wen), .rx_bit_valid(rxv), .rx_bit(rxb));
    spe_prog_model spe_prog_model_i (.clk_sys, .pclk, .pdat, .mclr, .hvl);
    initial forever #50 clk_sys = ~clk_sys;
    // Count and collect received bits at their strobe
    always @(posedge clk_sys) begin
        if (rxv === 1'b1) begin
            nrx <= nrx + 1;
            rxw <= {rxw[30:0], rxb};
        end
    end
    task automatic chk(input string n, input logic s, input logic e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // High-level entry refused with data high, then taken; grant, drive, receive
    task automatic t_hv();
        int base;
        chk("force on", frc, 1'b1);
        spe_prog_model_i.drive_pins(1'b1, 1'b1, 1'b1);
        w(10);
        chk("hv data high", hv, 1'b0);
        spe_prog_model_i.drive_pins(1'b1, 1'b0, 1'b0);
        w(8);
        spe_prog_model_i.drive_pins(1'b1, 1'b1, 1'b0);
        w(10);
        chk("hv on", hv, 1'b1);
        chk("hv write", wen, 1'b1);
        txe <= 1'b1;
        txd <= 1'b1;
        req <= 1'b1;
        w(4);
        chk("data oe", doe, 1'b1);
        chk("data out", dout, 1'b1);
        chk("hv clear", ok, 1'b1);
        txe <= 1'b0;
        base = nrx;
        spe_prog_model_i.key(32'h3c96_a5f1);
        w(4);
        chk("rx count", nrx - base == 32, 1'b1);
        chk("rx word", rxw === 32'h3c96_a5f1, 1'b1);
        chk("data released", doe, 1'b0);
        req <= 1'b0;
        spe_prog_model_i.drive_pins(1'b1, 1'b0, 1'b0);
        w(8);
        chk("hv off", hv, 1'b0);
    endtask
    // Wrong key locks out until a fresh low; then good key holds while low
    task automatic t_lv();
        spe_prog_model_i.drive_pins(1'b0, 1'b0, 1'b0);
        w(8);
        spe_prog_model_i.key(~`SPE_KEY_VALUE);
        w(12);
        chk("lv bad", lv, 1'b0);
        spe_prog_model_i.key(`SPE_KEY_VALUE);
        w(12);
        chk("lv locked", lv, 1'b0);
        spe_prog_model_i.drive_pins(1'b1, 1'b0, 1'b0);
        w(8);
        spe_prog_model_i.drive_pins(1'b0, 1'b0, 1'b0);
        w(8);
        spe_prog_model_i.key(`SPE_KEY_VALUE);
        w(12);
        chk("lv good", lv, 1'b1);
        chk("lv mode", mode, 1'b1);
        chk("lv write", wen, 1'b1);
        w(40);
        chk("lv hold", lv, 1'b1);
        req <= 1'b1;
        w(4);
        chk("lv clear", ok, 1'b0);
        req <= 1'b0;
        spe_prog_model_i.drive_pins(1'b1, 1'b0, 1'b0);
        w(8);
        chk("lv end", lv, 1'b0);
    endtask
    // Key path dead while the enable bit is clear
    task automatic t_off();
        en <= 1'b0;
        w(3);
        chk("force off", frc, 1'b0);
        spe_prog_model_i.drive_pins(1'b0, 1'b0, 1'b0);
        w(8);
        spe_prog_model_i.key(`SPE_KEY_VALUE);
        w(12);
        chk("lv off", lv, 1'b0);
        chk("mode off", mode, 1'b0);
    endtask
    initial begin
        w(4);
        srst <= 1'b0;
        w(4);
        t_hv();
        t_lv();
        t_off();
        summarize();
    end
    // Watchdog: run needs about 1500 cycles
    initial begin
        w(6000);
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
